// >>> pkg/apc_map.vh
// Register map, field positions, codes and reset values of the absolute position block
// ==========================================================================
`ifndef APC_MAP_VH
`define APC_MAP_VH
`define APC_A_CTRL     8'h00
`define APC_A_TEACH    8'h04
`define APC_A_STATUS   8'h08
`define APC_A_CURPOS   8'h0C
`define APC_A_DEV      8'h10
`define APC_A_STAGE0   8'h20
// CTRL fields
`define APC_F_VF_LO    0
`define APC_F_CPS_LO   8
`define APC_F_RMS_LO   16
`define APC_F_ZRM_LO   24
`define APC_F_ZRDIR    26
`define APC_F_SPSEL_ASG 27
`define APC_F_CLR_ASG   28
`define APC_F_TEACH_ASG 29
// Codes
`define APC_VF_SENSOR  8'h02
`define APC_CPS_ABS    8'h02
`define APC_CPS_ABS4   8'h03
`define APC_RMS_TRIP   8'h03
`define APC_ZR_LOW     2'h0
`define APC_ZR_HI2     2'h2
`define APC_CTRL_RST   32'h00000000
`define APC_SLOT_RST   3'h0
`define APC_DECEL_DIST 32'h00000040
`endif

// >>> design/apc_top.v
// Absolute position control, teaching and register port of the motor drive
`timescale 1ns/1ps
`include "apc_map.vh"
module apc_top #(
   parameter [31:0] DECEL_DIST = `APC_DECEL_DIST
) (
   input  wire        REF_CLK,
   input  wire        RESETN,
   input  wire [7:0]  REG_ADDR,
   input  wire [31:0] REG_WDATA,
   input  wire        REG_WR,
   input  wire        REG_RD,
   output reg  [31:0] REG_RDATA,
   input  wire        ENC_A,
   input  wire        ENC_B,
   input  wire        RUN_CMD,
   input  wire        FWD_REV,
   input  wire [2:0]  STAGE_SEL,
   input  wire        SPEED_POSITION_SELECT_INPUT,
   input  wire        POSITION_CLEAR_INPUT,
   input  wire        TORQUE_CONTROL_ENABLE_INPUT,
   input  wire        PULSE_TRAIN_ENABLE_INPUT,
   input  wire        ORIENTATION_TEACH_INPUT,
   input  wire        STORE_KEY,
   input  wire        TERM_RESET,
   input  wire        ZERO_RETURN_REQ,
   input  wire        HOME_SEARCH_REQ,
   input  wire        HOME_SWITCH,
   output reg         DRV_RUN,
   output reg         DRV_REV,
   output reg         DRV_DECEL,
   output reg         DRV_HI_SPEED,
   output reg         SERVO_LOCK,
   output reg         POS_DONE,
   output reg         ZR_BUSY,
   output reg         HOME_SEARCH_RUN,
   output reg         TORQUE_CTRL_ON,
   output reg         PULSE_TRAIN_ON,
   output reg         TRIP_CLEAR
);
   // ==========================================================================
   // States
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_MOVE = 3'h1;
   localparam [2:0] S_LOCK = 3'h2;
   localparam [2:0] S_DONE = 3'h3;
   localparam [2:0] S_ZRET = 3'h4;
   localparam [2:0] S_JOG  = 3'h5;

   // ==========================================================================
   // Registers
   reg  [31:0] ctrl_r;
   reg  [2:0]  teach_slot_select_r;
   reg  [31:0] stage_r [0:7];
   reg  [31:0] cur_pos_r;
   reg  [31:0] dev_r;
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg         enc_a_r;
   reg         enc_b_r;
   reg         run_r;
   reg         term_reset_r;
   reg         zr_req_r;
   reg         store_r;
   integer     i;

   function is_stage;
      input [7:0] a;
      begin
         is_stage = (a[7:5] == `APC_A_STAGE0 >> 5) && (a[1:0] == 2'h0);
      end
   endfunction

   wire [7:0]  vf_curve_select        = ctrl_r[`APC_F_VF_LO+7:`APC_F_VF_LO];
   wire [7:0]  control_pulse_select   = ctrl_r[`APC_F_CPS_LO+7:`APC_F_CPS_LO];
   wire [7:0]  reset_mode_select      = ctrl_r[`APC_F_RMS_LO+7:`APC_F_RMS_LO];
   wire [1:0]  zero_return_mode       = ctrl_r[`APC_F_ZRM_LO+1:`APC_F_ZRM_LO];
   wire        zr_dir                 = ctrl_r[`APC_F_ZRDIR];
   wire        speed_sel_assigned     = ctrl_r[`APC_F_SPSEL_ASG];
   wire        clear_assigned         = ctrl_r[`APC_F_CLR_ASG];
   wire        teach_assigned         = ctrl_r[`APC_F_TEACH_ASG];

   // ==========================================================================
   // Mode decode
   wire cps_abs   = (control_pulse_select == `APC_CPS_ABS) ||
                    (control_pulse_select == `APC_CPS_ABS4);
   wire hi_res    = (control_pulse_select == `APC_CPS_ABS4);
   wire abs_cfg   = (vf_curve_select == `APC_VF_SENSOR) && cps_abs;
   // Speed/position select high means speed control
   wire abs_mode  = abs_cfg && !(speed_sel_assigned && SPEED_POSITION_SELECT_INPUT);
   wire teach_on  = cps_abs && teach_assigned && ORIENTATION_TEACH_INPUT;
   wire clear_on  = clear_assigned && POSITION_CLEAR_INPUT;
   wire [31:0] target = stage_r[STAGE_SEL];
   wire run_rise  = RUN_CMD && !run_r;
   wire rst_rise  = TERM_RESET && !term_reset_r;
   wire zr_rise   = ZERO_RETURN_REQ && !zr_req_r;
   wire store_rise = STORE_KEY && !store_r;
   wire [31:0] dev_now = target - cur_pos_r;
   wire [31:0] dev_abs = dev_now[31] ? (32'h00000000 - dev_now) : dev_now;

   // ==========================================================================
   // Encoder decode
   // x1 counts A rising only; x4 counts every A or B edge
   wire a_edge   = ENC_A ^ enc_a_r;
   wire b_edge   = ENC_B ^ enc_b_r;
   wire q_up     = ENC_A ^ enc_b_r;
   wire step_x1  = a_edge && ENC_A;
   wire step_x4  = a_edge || b_edge;
   wire enc_step = hi_res ? step_x4 : step_x1;
   wire enc_up   = hi_res ? q_up : !ENC_B;

   // ==========================================================================
   // Position and deviation counters
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cur_pos_r <= 32'h00000000;
         dev_r     <= 32'h00000000;
      end else begin
         if (clear_on) begin
            cur_pos_r <= 32'h00000000;
            dev_r     <= 32'h00000000;
         end else if (state_r == S_ZRET && HOME_SWITCH) begin
            cur_pos_r <= 32'h00000000;
            dev_r     <= dev_now;
         end else if (rst_rise && reset_mode_select != `APC_RMS_TRIP) begin
            cur_pos_r <= 32'h00000000;
            dev_r     <= dev_now;
         end else begin
            // Counts regardless of drive state, so external moves are tracked
            if (enc_step) begin
               cur_pos_r <= enc_up ? cur_pos_r + 32'h00000001 :
                                     cur_pos_r - 32'h00000001;
            end
            dev_r <= dev_now;
         end
      end
   end

   // ==========================================================================
   // Sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (abs_mode && zr_rise) begin
               state_nxt = S_ZRET;
            end else if (abs_mode && run_rise) begin
               if (teach_on) begin
                  state_nxt = S_JOG;
               end else if (target == 32'h00000000) begin
                  state_nxt = S_DONE;
               end else begin
                  state_nxt = S_MOVE;
               end
            end
         end
         S_MOVE: begin
            if (!RUN_CMD || !abs_mode) begin
               state_nxt = S_IDLE;
            end else if (dev_now == 32'h00000000) begin
               state_nxt = S_LOCK;
            end
         end
         S_LOCK: begin
            if (!RUN_CMD || !abs_mode) begin
               state_nxt = S_IDLE;
            end
         end
         S_DONE: begin
            if (!RUN_CMD || !abs_mode) begin
               state_nxt = S_IDLE;
            end
         end
         S_ZRET: begin
            if (HOME_SWITCH || !abs_mode) begin
               state_nxt = S_IDLE;
            end
         end
         S_JOG: begin
            // Leaving absolute mode hands the drive back to speed control
            if (!RUN_CMD || !abs_mode) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // ==========================================================================
   // State, edge history and drive outputs
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r         <= S_IDLE;
         enc_a_r         <= 1'b0;
         enc_b_r         <= 1'b0;
         run_r           <= 1'b0;
         term_reset_r    <= 1'b0;
         zr_req_r        <= 1'b0;
         store_r         <= 1'b0;
         DRV_RUN         <= 1'b0;
         DRV_REV         <= 1'b0;
         DRV_DECEL       <= 1'b0;
         DRV_HI_SPEED    <= 1'b0;
         SERVO_LOCK      <= 1'b0;
         POS_DONE        <= 1'b0;
         ZR_BUSY         <= 1'b0;
         HOME_SEARCH_RUN <= 1'b0;
         TORQUE_CTRL_ON  <= 1'b0;
         PULSE_TRAIN_ON  <= 1'b0;
         TRIP_CLEAR      <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         enc_a_r      <= ENC_A;
         enc_b_r      <= ENC_B;
         run_r        <= RUN_CMD;
         term_reset_r <= TERM_RESET;
         zr_req_r     <= ZERO_RETURN_REQ;
         store_r      <= STORE_KEY;
         TRIP_CLEAR   <= rst_rise;
         ZR_BUSY      <= (state_nxt == S_ZRET);
         SERVO_LOCK   <= (state_nxt == S_LOCK);
         POS_DONE     <= (state_nxt == S_LOCK) || (state_nxt == S_DONE);
         // Home search blocked in absolute mode and during zero return
         HOME_SEARCH_RUN <= HOME_SEARCH_REQ && !abs_mode && !abs_cfg;
         TORQUE_CTRL_ON  <= TORQUE_CONTROL_ENABLE_INPUT && !abs_mode;
         PULSE_TRAIN_ON  <= PULSE_TRAIN_ENABLE_INPUT && !abs_mode;
         if (!abs_mode) begin
            // Speed control: run command keeps its own direction
            DRV_RUN      <= RUN_CMD;
            DRV_REV      <= FWD_REV;
            DRV_DECEL    <= 1'b0;
            DRV_HI_SPEED <= 1'b0;
         end else begin
            case (state_nxt)
               S_MOVE: begin
                  DRV_RUN      <= 1'b1;
                  DRV_REV      <= dev_now[31];
                  // Short moves enter the window before reaching set speed
                  DRV_DECEL    <= (dev_abs <= DECEL_DIST);
                  DRV_HI_SPEED <= 1'b0;
               end
               S_ZRET: begin
                  DRV_RUN      <= 1'b1;
                  DRV_REV      <= zr_dir;
                  DRV_DECEL    <= 1'b0;
                  DRV_HI_SPEED <= (zero_return_mode != `APC_ZR_LOW);
               end
               S_JOG: begin
                  DRV_RUN      <= 1'b1;
                  DRV_REV      <= FWD_REV;
                  DRV_DECEL    <= 1'b0;
                  DRV_HI_SPEED <= 1'b0;
               end
               default: begin
                  DRV_RUN      <= 1'b0;
                  DRV_REV      <= 1'b0;
                  DRV_DECEL    <= 1'b0;
                  DRV_HI_SPEED <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==========================================================================
   // Register writes and teaching store
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r              <= `APC_CTRL_RST;
         teach_slot_select_r <= `APC_SLOT_RST;
         for (i = 0; i < 8; i = i + 1) begin
            stage_r[i] <= 32'h00000000;
         end
      end else begin
         if (REG_WR && REG_ADDR == `APC_A_CTRL) begin
            ctrl_r <= REG_WDATA;
         end else if (REG_WR && REG_ADDR == `APC_A_TEACH) begin
            teach_slot_select_r <= REG_WDATA[2:0];
         end
         // Store key wins over a bus write to any stage slot
         if (teach_on && store_rise) begin
            stage_r[teach_slot_select_r] <= cur_pos_r;
         end else if (REG_WR && is_stage(REG_ADDR)) begin
            stage_r[REG_ADDR[4:2]] <= REG_WDATA;
         end
      end
   end

   // ==========================================================================
   // Register reads, data in the following cycle
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         REG_RDATA <= 32'h00000000;
      end else if (REG_RD) begin
         if (REG_ADDR == `APC_A_CTRL) begin
            REG_RDATA <= ctrl_r;
         end else if (REG_ADDR == `APC_A_TEACH) begin
            REG_RDATA <= {29'h00000000, teach_slot_select_r};
         end else if (REG_ADDR == `APC_A_STATUS) begin
            REG_RDATA <= {22'h000000, teach_on, abs_mode, abs_cfg, state_r,
                          POS_DONE, SERVO_LOCK, ZR_BUSY, DRV_RUN};
         end else if (REG_ADDR == `APC_A_CURPOS) begin
            REG_RDATA <= cur_pos_r;
         end else if (REG_ADDR == `APC_A_DEV) begin
            REG_RDATA <= dev_r;
         end else if (is_stage(REG_ADDR)) begin
            REG_RDATA <= stage_r[REG_ADDR[4:2]];
         end else begin
            REG_RDATA <= 32'h00000000;
         end
      end else begin
         REG_RDATA <= 32'h00000000;
      end
   end

endmodule // apc_top

// >>> verif/apc_top_asserts.sv
// Port-level assertions of the absolute position block
`timescale 1ns/1ps
module apc_top_asserts (
   input logic        REF_CLK,
   input logic        RESETN,
   input logic [7:0]  REG_ADDR,
   input logic [31:0] REG_WDATA,
   input logic        REG_WR,
   input logic        RUN_CMD,
   input logic        SPEED_POSITION_SELECT_INPUT,
   input logic        TERM_RESET,
   input logic        HOME_SWITCH,
   input logic        DRV_RUN,
   input logic        DRV_REV,
   input logic        DRV_HI_SPEED,
   input logic        SERVO_LOCK,
   input logic        POS_DONE,
   input logic        ZR_BUSY,
   input logic        HOME_SEARCH_RUN,
   input logic        TORQUE_CTRL_ON,
   input logic        PULSE_TRAIN_ON,
   input logic        TRIP_CLEAR
);
   // ==========================================
   // Shadow of the control word
   logic [31:0] ctrl_r;
   logic        cfg_r;
   wire         abs_cfg = ctrl_r[7:0] == 8'h02 && ctrl_r[15:9] == 7'h01;
   // Assigned speed select high leaves absolute mode
   wire         abs_now = abs_cfg && !(ctrl_r[27] && SPEED_POSITION_SELECT_INPUT);
   // Config must hold two edges, so the registered gates have settled
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r <= 32'h00000000;
         cfg_r  <= 1'b0;
      end else begin
         if (REG_WR && REG_ADDR == 8'h00) ctrl_r <= REG_WDATA;
         cfg_r <= abs_now;
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   chk_torque_gate: assert property (cfg_r && abs_cfg |-> !TORQUE_CTRL_ON)
      else $error("torque enable passed in absolute mode");
   chk_pulse_gate: assert property (cfg_r && abs_cfg |-> !PULSE_TRAIN_ON)
      else $error("pulse train enable passed in absolute mode");
   chk_home_abs: assert property (cfg_r && abs_cfg |-> !HOME_SEARCH_RUN)
      else $error("home search ran in absolute mode");
   chk_zr_nohome: assert property (ZR_BUSY |-> !HOME_SEARCH_RUN)
      else $error("home search ran during zero return");
   chk_trip_pulse: assert property ($rose(TERM_RESET) |=> TRIP_CLEAR ##1 !TRIP_CLEAR)
      else $error("trip clear pulse wrong");
   chk_lock_idle: assert property (SERVO_LOCK |-> !DRV_RUN && POS_DONE)
      else $error("servo lock with drive on or not done");
   chk_lock_hold: assert property (SERVO_LOCK && RUN_CMD && abs_now |=> SERVO_LOCK)
      else $error("servo lock dropped while run held");
   chk_lock_release: assert property (SERVO_LOCK && !RUN_CMD |=> !SERVO_LOCK && !POS_DONE)
      else $error("servo lock kept after stop");
   chk_zr_drive: assert property (ZR_BUSY |-> DRV_RUN && DRV_REV == ctrl_r[26] &&
      DRV_HI_SPEED == (ctrl_r[25:24] != 2'h0)) else $error("zero return drive wrong");
   chk_zr_end: assert property (ZR_BUSY && HOME_SWITCH |=> !ZR_BUSY)
      else $error("zero return did not end at origin");
   chk_done_still: assert property (POS_DONE |-> !DRV_RUN)
      else $error("drive on while positioning complete");
   cov_trip: cover property (TRIP_CLEAR);
   cov_lock_end: cover property (SERVO_LOCK ##1 !SERVO_LOCK);
   cov_zr_home: cover property (ZR_BUSY && HOME_SWITCH);
   cov_done_only: cover property (POS_DONE && !SERVO_LOCK);
endmodule // apc_top_asserts
bind apc_top apc_top_asserts i_chk (.*);

// >>> verif/apc_enc_model.sv
// Quadrature encoder model, one phase per step request
`timescale 1ns/1ps
module apc_enc_model (
   input  logic ref_clk,
   input  logic resetn,
   input  logic step,
   input  logic dir,
   output logic enc_a,
   output logic enc_b
);
   logic [1:0] ph_r;
   // Gray order: only one line moves per phase, as on a real disc
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) ph_r <= 2'h0;
      else if (step) ph_r <= dir ? ph_r - 2'h1 : ph_r + 2'h1;
   end
   assign enc_a = ph_r == 2'h1 || ph_r == 2'h2;
   assign enc_b = ph_r[1];
endmodule // apc_enc_model

// >>> verif/absolute_position_control_test.sv
// Self-checking bench of the absolute position block with an encoder model
`timescale 1ns/1ps
module absolute_position_control_test;
   logic        REF_CLK, RESETN, REG_WR, REG_RD, ENC_A, ENC_B, RUN_CMD, FWD_REV, STORE_KEY, TERM_RESET;
   logic [7:0]  REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA, v;
   logic [2:0]  STAGE_SEL;
   logic        SPEED_POSITION_SELECT_INPUT, POSITION_CLEAR_INPUT, TORQUE_CONTROL_ENABLE_INPUT;
   logic        PULSE_TRAIN_ENABLE_INPUT, ORIENTATION_TEACH_INPUT, ZERO_RETURN_REQ, HOME_SEARCH_REQ, HOME_SWITCH;
   logic        DRV_RUN, DRV_REV, DRV_DECEL, DRV_HI_SPEED, SERVO_LOCK, POS_DONE, ZR_BUSY, HOME_SEARCH_RUN;
   logic        TORQUE_CTRL_ON, PULSE_TRAIN_ON, TRIP_CLEAR, stp, sdir;
   integer      error_cnt = 0, samples_checked = 0, pos = 0, x4 = 0, stg[8], i, m, d;
   apc_top #(.DECEL_DIST(32'h00000004)) i_dut (.*);
   apc_enc_model i_enc (.ref_clk(REF_CLK), .resetn(RESETN), .step(stp), .dir(sdir), .enc_a(ENC_A), .enc_b(ENC_B));
   // ==========================================
   // Bus, encoder and compare tasks
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] dt);
      @(posedge REF_CLK);
      REG_ADDR  <= a;
      REG_WDATA <= dt;
      REG_WR    <= 1'b1;
      @(posedge REF_CLK);
      REG_WR    <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk = 32'hFFFFFFFF);
      @(posedge REF_CLK);
      REG_ADDR <= a;
      REG_RD   <= 1'b1;
      @(posedge REF_CLK);
      REG_RD   <= 1'b0;
      #1 chk(REG_RDATA & mk, e);
   endtask
   // Whole counts only; x1 needs four phases per count
   task enc(input integer n);
      repeat ((n < 0 ? -n : n) * (x4 ? 1 : 4)) begin
         @(posedge REF_CLK);
         stp  <= 1'b1;
         sdir <= n < 0;
         @(posedge REF_CLK);
         stp  <= 1'b0;
      end
      pos = pos + n;
      cyc(3);
   endtask
   task move(input integer s);
      STAGE_SEL <= s[2:0];
      FWD_REV   <= 1'($urandom);
      RUN_CMD   <= 1'b1;
      cyc(2);
      chk(DRV_RUN, stg[s] != pos);
      chk(DRV_REV, stg[s] < pos);
      if (stg[s] != pos) chk(DRV_DECEL, stg[s] - pos <= 4 && pos - stg[s] <= 4);
      rdc(8'h10, stg[s] - pos);
      enc(stg[s] - pos);
      chk({POS_DONE, DRV_RUN}, 2'b10);
      if (stg[s] != 0) chk(SERVO_LOCK, 1'b1);
      rdc(8'h0C, pos);
      rdc(8'h10, 32'h0);
      RUN_CMD <= 1'b0;
      cyc(2);
      chk({SERVO_LOCK, POS_DONE}, 2'b00);
   endtask
   task conclude;
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end
   initial begin
      repeat (20000) @(posedge REF_CLK);
      error_cnt++;
      conclude;
   end
   // ==========================================
   // Main sequence
   initial begin
      {RESETN, REG_WR, REG_RD, REG_ADDR, REG_WDATA, RUN_CMD, FWD_REV, STAGE_SEL, stp, sdir} = '0;
      {SPEED_POSITION_SELECT_INPUT, POSITION_CLEAR_INPUT, TORQUE_CONTROL_ENABLE_INPUT, STORE_KEY} = '0;
      {PULSE_TRAIN_ENABLE_INPUT, ORIENTATION_TEACH_INPUT, TERM_RESET, ZERO_RETURN_REQ} = '0;
      {HOME_SEARCH_REQ, HOME_SWITCH} = '0;
      v = $urandom(15);
      repeat (5) @(posedge REF_CLK);
      RESETN <= 1'b1;
      for (i = 0; i < 8; i++) rdc(8'h20 + 8'(4 * i), 32'h0);
      rdc(8'h0C, 32'h0);
      rdc(8'h04, 32'h0);
      rdc(8'hFC, 32'h0);
      wr(8'h0C, 32'h00000055);
      rdc(8'h0C, 32'h0);
      $display("test reset values done");
      wr(8'h00, 32'h38000202);
      for (i = 0; i < 8; i++) begin
         stg[i] = (i == 0) ? 0 : i * 7 - 20 + $urandom % 5;
         wr(8'h20 + 8'(4 * i), stg[i]);
      end
      for (i = 0; i < 8; i++) rdc(8'h20 + 8'(4 * i), stg[i]);
      $display("test stages done");
      move(0);
      move(3);
      move(1);
      wr(8'h00, 32'h38000302);
      x4 = 1;
      move(5);
      move(2);
      enc(6);
      rdc(8'h0C, pos);
      $display("test moves done");
      wr(8'h04, 32'h00000005);
      {ORIENTATION_TEACH_INPUT, FWD_REV, RUN_CMD} <= 3'b111;
      cyc(2);
      chk({DRV_RUN, DRV_REV}, 2'b11);
      enc(-3);
      STORE_KEY <= 1'b1;
      cyc(2);
      {STORE_KEY, RUN_CMD, ORIENTATION_TEACH_INPUT} <= 3'b000;
      stg[5] = pos;
      rdc(8'h34, stg[5]);
      rdc(8'h04, 32'h00000005);
      $display("test teach done");
      POSITION_CLEAR_INPUT <= 1'b1;
      rdc(8'h0C, 32'h0);
      rdc(8'h10, 32'h0);
      POSITION_CLEAR_INPUT <= 1'b0;
      pos = 0;
      enc(5);
      wr(8'h00, 32'h38030302);
      TERM_RESET <= 1'b1;
      cyc(1);
      chk(TRIP_CLEAR, 1'b1);
      TERM_RESET <= 1'b0;
      rdc(8'h0C, pos);
      wr(8'h00, 32'h38000302);
      TERM_RESET <= 1'b1;
      cyc(2);
      TERM_RESET <= 1'b0;
      pos = 0;
      rdc(8'h0C, 32'h0);
      $display("test clear and reset terminal done");
      for (m = 0; m < 3; m++) begin
         d = $urandom % 2;
         wr(8'h00, 32'h38000302 | (m << 24) | (d << 26));
         enc(3);
         {ZERO_RETURN_REQ, HOME_SEARCH_REQ} <= 2'b11;
         cyc(2);
         chk({ZR_BUSY, DRV_RUN, DRV_HI_SPEED, DRV_REV, HOME_SEARCH_RUN}, {2'b11, m != 0, d[0], 1'b0});
         {ZERO_RETURN_REQ, HOME_SWITCH} <= 2'b01;
         cyc(2);
         HOME_SWITCH <= 1'b0;
         pos = 0;
         chk(ZR_BUSY, 1'b0);
         rdc(8'h0C, 32'h0);
      end
      $display("test zero return done");
      {TORQUE_CONTROL_ENABLE_INPUT, PULSE_TRAIN_ENABLE_INPUT} <= 2'b11;
      cyc(2);
      chk({TORQUE_CTRL_ON, PULSE_TRAIN_ON, HOME_SEARCH_RUN}, 3'b000);
      wr(8'h00, 32'h38000301);
      cyc(2);
      chk({TORQUE_CTRL_ON, PULSE_TRAIN_ON, HOME_SEARCH_RUN}, 3'b111);
      {TORQUE_CONTROL_ENABLE_INPUT, PULSE_TRAIN_ENABLE_INPUT, HOME_SEARCH_REQ} <= 3'b000;
      wr(8'h00, 32'h38000302);
      SPEED_POSITION_SELECT_INPUT <= 1'b1;
      cyc(1);
      rdc(8'h08, 32'h0, 32'h00000100);
      SPEED_POSITION_SELECT_INPUT <= 1'b0;
      cyc(1);
      rdc(8'h08, 32'h00000100, 32'h00000100);
      $display("test mode gates done");
      enc(4);
      RESETN <= 1'b0;
      cyc(2);
      RESETN <= 1'b1;
      rdc(8'h04, 32'h0);
      rdc(8'h0C, 32'h0);
      $display("test second reset done");
      conclude;
   end
endmodule // absolute_position_control_test
